// ---- verilog/ocm_cfg.svh ----
// Purpose : Constants of the output compare mode control block
// Assumes : 16-bit registers, one 32-bit word each
// Notes   : Offsets are byte addresses
`ifndef OCM_CFG_SVH
`define OCM_CFG_SVH

`define OCM_ADDR_W          8
`define OCM_DATA_W          16

`define OCM_OFF_CONTROL_1   8'h00
`define OCM_OFF_CONTROL_2   8'h04
`define OCM_OFF_PRIMARY     8'h08
`define OCM_OFF_SECONDARY   8'h0c
`define OCM_OFF_TIMER       8'h10
`define OCM_OFF_PERIOD      8'h14
`define OCM_OFF_IRQ_STATUS  8'h18
`define OCM_OFF_IRQ_MASK    8'h1c

`define OCM_POS_TRIG_MODE   3
`define OCM_POS_TIMER_EN    15
`define OCM_POS_TRIG_FLAG   6

`define OCM_RST_CONTROL     16'h0000
`define OCM_RST_COMPARE     16'h0000
`define OCM_RST_PERIOD      16'hffff
`define OCM_RST_MASK        3'h0

`define OCM_MODE_OFF        3'h0
`define OCM_MODE_SS_HIGH    3'h1
`define OCM_MODE_SS_LOW     3'h2
`define OCM_MODE_TOGGLE     3'h3
`define OCM_MODE_DBL_SHOT   3'h4
`define OCM_MODE_DBL_CONT   3'h5
`define OCM_MODE_PWM_EDGE   3'h6
`define OCM_MODE_PWM_CENTER 3'h7

`define OCM_IRQ_PRIMARY     0
`define OCM_IRQ_SECONDARY   1
`define OCM_IRQ_PERIOD      2
`define OCM_IRQ_W           3

`define OCM_TRIG_BASE       3'h3

`endif

// ---- verilog/ocm_pkg.sv ----
// Purpose : Types shared by the output compare mode control files
// Assumes : Constants come from ocm_cfg.svh
// Notes   : Types only
`include "ocm_cfg.svh"

package ocm_pkg;

    typedef struct packed {
        logic       timer_enable;
        logic [10:0] spare;
        logic       trigger_status_clear_mode;
        logic [2:0] compare_mode_field;
    } ocm_ctrl1_type;

    typedef struct packed {
        logic primary;
        logic secondary;
        logic zero;
    } ocm_match_type;

endpackage

// ---- verilog/ocm_pin_sync.sv ----
// Purpose : Three-stage synchroniser with agreement filter for a pin
// Assumes : Pin is asynchronous to ref_clk
// Notes   : First stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none

module ocm_pin_sync (
    input  wire logic ref_clk,   // Clock
    input  wire logic reset,     // Synchronous reset, high
    input  wire logic clk_en,    // Freezes state while low
    input  wire logic pin_in,    // Asynchronous pin level
    output logic      level_q    // Filtered level
);

    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else if (clk_en) begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change counts once the second and third stages agree
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            level_q <= 1'b0;
        end else if (clk_en && (s2_q == s3_q)) begin
            level_q <= s3_q;
        end
    end

endmodule

`default_nettype wire

// ---- verilog/ocm_compare.sv ----
// Purpose : Equality detection of the channel timer against compare values
// Assumes : Inputs stable within the cycle
// Notes   : Purely combinational
`timescale 1ns/1ns
`default_nettype none

module ocm_compare #(
    parameter int W = 16
) (
    input  wire logic [W-1:0]     timer_value,  // Channel timer
    input  wire logic [W-1:0]     primary,      // Active primary value
    input  wire logic [W-1:0]     secondary,    // Active secondary value
    output ocm_pkg::ocm_match_type match        // Match flags
);

    always_comb begin
        match.primary   = (timer_value == primary);
        match.secondary = (timer_value == secondary);
        match.zero      = (timer_value == '0);
    end

endmodule

`default_nettype wire

// ---- verilog/ocm_channel.sv ----
// Purpose : Mode and trigger-status control of one output compare channel
// Assumes : Plain register port, read data one cycle after the read strobe
// Notes   : Timer counts 0..period; a synchronised pin clears it
//
// Local design decisions: strobed register access and the register addresses.
`include "ocm_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module ocm_channel #(
    parameter int        W       = `OCM_DATA_W,
    parameter int        AW      = `OCM_ADDR_W,
    parameter logic [2:0] CHANNEL = 3'h1
) (
    input  wire logic          ref_clk,         // Peripheral clock, 100 MHz
    input  wire logic          reset,           // Synchronous reset, high
    input  wire logic          clk_en,          // Freezes all state while low
    input  wire logic [AW-1:0] reg_addr,        // Register byte address
    input  wire logic [31:0]   reg_wdata,       // Register write data
    input  wire logic          reg_write,       // Write strobe
    input  wire logic          reg_read,        // Read strobe
    output logic      [31:0]   reg_rdata,       // Read data, cycle after strobe
    input  wire logic          timer_sync_pin,  // External timer clear pin
    output logic               compare_output_pin, // Compare pin level
    output logic               compare_output_oe,  // Pin driven while mode is not off
    output logic               trigger_generator_pulse, // Trigger to generator
    output logic      [2:0]    trigger_generator_index, // Generator input number
    output logic               irq                 // Level interrupt
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    ocm_pkg::ocm_ctrl1_type   ctrl1_q;
    ocm_pkg::ocm_match_type   match;
    logic [W-1:0]             primary_buf_q;
    logic [W-1:0]             secondary_buf_q;
    logic [W-1:0]             primary_act_q;
    logic [W-1:0]             secondary_act_q;
    logic [W-1:0]             period_q;
    logic [W-1:0]             timer_q;
    logic                     trig_flag_q;
    logic                     pin_q;
    logic                     shot_done_q;
    logic                     phase_q;
    logic [`OCM_IRQ_W-1:0]    irq_status_q;
    logic [`OCM_IRQ_W-1:0]    irq_mask_q;
    logic [`OCM_IRQ_W-1:0]    irq_event;
    logic [`OCM_IRQ_W-1:0]    irq_status_d;
    logic                     sync_level_q;
    logic                     sync_level_prev_q;
    logic                     sync_clear;
    logic                     period_start;
    logic                     pwm_mode;
    logic                     mode_write;
    logic                     active;
    logic [2:0]               mode;
    logic [W-1:0]             wdata;

    assign wdata      = reg_wdata[W-1:0];
    assign mode       = ctrl1_q.compare_mode_field;
    assign pwm_mode   = (mode == `OCM_MODE_PWM_EDGE) || (mode == `OCM_MODE_PWM_CENTER);
    assign active     = (mode != `OCM_MODE_OFF) && ctrl1_q.timer_enable;
    assign mode_write = reg_write && (reg_addr == `OCM_OFF_CONTROL_1);
    assign sync_clear = sync_level_q && !sync_level_prev_q;
    assign period_start = active && (timer_q == period_q);

    // ------------------------------------------------------------------
    // Sub blocks
    // ------------------------------------------------------------------
    ocm_pin_sync u_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .clk_en  (clk_en),
        .pin_in  (timer_sync_pin),
        .level_q (sync_level_q)
    );

    ocm_compare #(
        .W (W)
    ) u_compare (
        .timer_value (timer_q),
        .primary     (primary_act_q),
        .secondary   (secondary_act_q),
        .match       (match)
    );

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl1_q  <= `OCM_RST_CONTROL;
            period_q <= `OCM_RST_PERIOD;
        end else if (clk_en && reg_write) begin
            if (reg_addr == `OCM_OFF_CONTROL_1) begin
                ctrl1_q <= wdata;
            end
            if (reg_addr == `OCM_OFF_PERIOD) begin
                period_q <= wdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            primary_buf_q   <= `OCM_RST_COMPARE;
            secondary_buf_q <= `OCM_RST_COMPARE;
        end else if (clk_en && reg_write) begin
            if (reg_addr == `OCM_OFF_PRIMARY) begin
                primary_buf_q <= wdata;
            end
            if (reg_addr == `OCM_OFF_SECONDARY) begin
                secondary_buf_q <= wdata;
            end
        end
    end

    // Outside PWM the active values follow writes at once; in PWM they
    // load only at the period boundary or while inactive, so no period mixes old and new.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            primary_act_q   <= `OCM_RST_COMPARE;
            secondary_act_q <= `OCM_RST_COMPARE;
        end else if (clk_en) begin
            if (!pwm_mode || period_start || !active) begin
                primary_act_q   <= primary_buf_q;
                secondary_act_q <= secondary_buf_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Channel timer
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            timer_q           <= '0;
            sync_level_prev_q <= 1'b0;
        end else if (clk_en) begin
            sync_level_prev_q <= sync_level_q;
            if (!active || sync_clear || period_start) begin
                timer_q <= '0;
            end else begin
                timer_q <= timer_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Output waveform
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pin_q       <= 1'b0;
            shot_done_q <= 1'b0;
            phase_q     <= 1'b0;
        end else if (clk_en) begin
            if (mode_write) begin
                // A new mode restarts from its initial level
                shot_done_q <= 1'b0;
                phase_q     <= 1'b0;
                pin_q       <= (wdata[2:0] == `OCM_MODE_SS_LOW);
            end else if (active) begin
                case (mode)
                    `OCM_MODE_SS_HIGH: begin
                        if (match.primary && !shot_done_q) begin
                            pin_q       <= 1'b1;
                            shot_done_q <= 1'b1;
                        end
                    end
                    `OCM_MODE_SS_LOW: begin
                        if (match.primary && !shot_done_q) begin
                            pin_q       <= 1'b0;
                            shot_done_q <= 1'b1;
                        end
                    end
                    `OCM_MODE_TOGGLE: begin
                        if (match.primary) begin
                            pin_q <= !pin_q;
                        end
                    end
                    `OCM_MODE_DBL_SHOT: begin
                        if (!shot_done_q && !phase_q && match.primary) begin
                            pin_q   <= 1'b1;
                            phase_q <= 1'b1;
                        end else if (!shot_done_q && phase_q && match.secondary) begin
                            pin_q       <= 1'b0;
                            phase_q     <= 1'b0;
                            shot_done_q <= 1'b1;
                        end
                    end
                    `OCM_MODE_DBL_CONT: begin
                        if (!phase_q && match.primary) begin
                            pin_q   <= 1'b1;
                            phase_q <= 1'b1;
                        end else if (phase_q && match.secondary) begin
                            pin_q   <= 1'b0;
                            phase_q <= 1'b0;
                        end
                    end
                    `OCM_MODE_PWM_EDGE: begin
                        // Primary wins over zero so a zero duty stays low
                        if (match.primary) begin
                            pin_q <= 1'b0;
                        end else if (match.zero) begin
                            pin_q <= 1'b1;
                        end
                    end
                    `OCM_MODE_PWM_CENTER: begin
                        if (match.secondary) begin
                            pin_q <= 1'b0;
                        end else if (match.primary) begin
                            pin_q <= 1'b1;
                        end
                    end
                    default: begin
                        pin_q <= 1'b0;
                    end
                endcase
            end else if (mode == `OCM_MODE_OFF) begin
                pin_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            compare_output_pin <= 1'b0;
            compare_output_oe  <= 1'b0;
        end else if (clk_en) begin
            compare_output_pin <= pin_q;
            compare_output_oe  <= (mode != `OCM_MODE_OFF);
        end
    end

    // ------------------------------------------------------------------
    // Trigger status and trigger source
    // ------------------------------------------------------------------
    // Set by a primary match; a set in the same cycle as a clear wins.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            trig_flag_q <= 1'b0;
        end else if (clk_en) begin
            if (active && match.primary) begin
                trig_flag_q <= 1'b1;
            end else if (reg_write && (reg_addr == `OCM_OFF_CONTROL_2)
                         && !reg_wdata[`OCM_POS_TRIG_FLAG]) begin
                trig_flag_q <= 1'b0;
            end else if (active && ctrl1_q.trigger_status_clear_mode && match.secondary) begin
                trig_flag_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            trigger_generator_pulse <= 1'b0;
            trigger_generator_index <= 3'h0;
        end else if (clk_en) begin
            trigger_generator_pulse <= active && match.primary;
            trigger_generator_index <= CHANNEL + `OCM_TRIG_BASE;
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    always_comb begin
        irq_event                     = '0;
        irq_event[`OCM_IRQ_PRIMARY]   = active && match.primary;
        irq_event[`OCM_IRQ_SECONDARY] = active && match.secondary;
        irq_event[`OCM_IRQ_PERIOD]    = period_start;
        irq_status_d = irq_status_q;
        if (reg_write && (reg_addr == `OCM_OFF_IRQ_STATUS)) begin
            irq_status_d = irq_status_q & ~reg_wdata[`OCM_IRQ_W-1:0];
        end
        // New events win over a clear in the same cycle
        irq_status_d = irq_status_d | irq_event;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_status_q <= '0;
            irq_mask_q   <= `OCM_RST_MASK;
            irq          <= 1'b0;
        end else if (clk_en) begin
            irq_status_q <= irq_status_d;
            if (reg_write && (reg_addr == `OCM_OFF_IRQ_MASK)) begin
                irq_mask_q <= reg_wdata[`OCM_IRQ_W-1:0];
            end
            irq <= |(irq_status_q & irq_mask_q);
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (clk_en) begin
            reg_rdata <= '0;
            if (reg_read) begin
                case (reg_addr)
                    `OCM_OFF_CONTROL_1:  reg_rdata <= {16'h0000, ctrl1_q};
                    `OCM_OFF_CONTROL_2:  reg_rdata <= {25'h0000000, trig_flag_q, 6'h00};
                    `OCM_OFF_PRIMARY:    reg_rdata <= {16'h0000, primary_buf_q};
                    `OCM_OFF_SECONDARY:  reg_rdata <= {16'h0000, secondary_buf_q};
                    `OCM_OFF_TIMER:      reg_rdata <= {16'h0000, timer_q};
                    `OCM_OFF_PERIOD:     reg_rdata <= {16'h0000, period_q};
                    `OCM_OFF_IRQ_STATUS: reg_rdata <= {29'h00000000, irq_status_q};
                    `OCM_OFF_IRQ_MASK:   reg_rdata <= {29'h00000000, irq_mask_q};
                    default:             reg_rdata <= '0;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// ---- verification/ocm_channel_monitor.sv ----
// Purpose : Port-level assertions for the output compare channel
// Assumes : Mode and mask shadowed from register writes
// Notes   : Mode checks wait three cycles for the pin lag
`include "ocm_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module ocm_channel_monitor #(
    parameter int         AW      = `OCM_ADDR_W,
    parameter logic [2:0] CHANNEL = 3'h1
) (
    input wire logic          ref_clk,                 // Clock
    input wire logic          reset,                   // Reset, high
    input wire logic          clk_en,                  // Run enable
    input wire logic [AW-1:0] reg_addr,                // Address
    input wire logic [31:0]   reg_wdata,               // Write data
    input wire logic          reg_write,               // Write strobe
    input wire logic          reg_read,                // Read strobe
    input wire logic [31:0]   reg_rdata,               // Read data
    input wire logic          timer_sync_pin,          // Timer clear pin
    input wire logic          compare_output_pin,      // Pin level
    input wire logic          compare_output_oe,       // Pin enable
    input wire logic          trigger_generator_pulse, // Trigger pulse
    input wire logic [2:0]    trigger_generator_index, // Generator input
    input wire logic          irq                      // Interrupt
);
    logic [2:0] mode_q;
    logic [2:0] mask_q;

    // ------------------------------------------------------------
    // Shadow of software settings
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode_q <= `OCM_MODE_OFF;
            mask_q <= `OCM_RST_MASK;
        end else if (clk_en && reg_write) begin
            if (reg_addr == `OCM_OFF_CONTROL_1) begin
                mode_q <= reg_wdata[2:0];
            end
            if (reg_addr == `OCM_OFF_IRQ_MASK) begin
                mask_q <= reg_wdata[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence mode_held(logic [2:0] m);
        (mode_q == m)[*3];
    endsequence

    a_rdata_idle_zero: assert property (clk_en && !reg_read |=> reg_rdata == 32'h0)
        else $error("read data not zero outside a read");
    a_index_fixed: assert property (!$past(reset) |-> trigger_generator_index == CHANNEL + 3'h3)
        else $error("trigger index wrong");
    a_pulse_single: assert property (trigger_generator_pulse && clk_en |=> !trigger_generator_pulse)
        else $error("trigger pulse longer than one cycle");
    a_irq_masked_off: assert property (mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !irq)
        else $error("interrupt with empty mask");
    a_idle_pin_low: assert property (mode_held(`OCM_MODE_OFF) |-> !compare_output_pin)
        else $error("pin active in disabled mode");
    a_idle_oe_off: assert property (mode_held(`OCM_MODE_OFF) |-> !compare_output_oe)
        else $error("pin driven in disabled mode");
    a_active_oe_on: assert property ((mode_q != 3'h0)[*3] |-> compare_output_oe)
        else $error("pin not driven in active mode");
    a_high_shot_stays: assert property (mode_held(`OCM_MODE_SS_HIGH) |-> !$fell(compare_output_pin))
        else $error("pin fell in single shot high mode");
    a_low_shot_stays: assert property (mode_held(`OCM_MODE_SS_LOW) |-> !$rose(compare_output_pin))
        else $error("pin rose in single shot low mode");
endmodule

bind ocm_channel ocm_channel_monitor #(.AW(AW), .CHANNEL(CHANNEL)) u_monitor (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .timer_sync_pin(timer_sync_pin),
    .compare_output_pin(compare_output_pin), .compare_output_oe(compare_output_oe),
    .trigger_generator_pulse(trigger_generator_pulse), .trigger_generator_index(trigger_generator_index),
    .irq(irq)
);

`default_nettype wire

// ---- verification/ocm_load_model.sv ----
// Purpose : Load on the compare pin that counts driven rising edges
// Assumes : One clock shared with the channel
// Notes   : Timer clear pin stays low
`timescale 1ns/1ns
`default_nettype none

module ocm_load_model (
    input wire logic   ref_clk,  // Clock
    input wire logic   pin,      // Compare pin level
    input wire logic   oe,       // Compare pin enable
    output var logic   sync_pin, // Timer clear pin
    output var logic [15:0] rises // Driven rising edges
);
    logic last_q;

    initial begin
        sync_pin = 1'b0;
        rises = 16'h0;
        last_q = 1'b0;
    end

    // Edges seen while undriven are noise, not compare activity
    always @(posedge ref_clk) begin
        if (oe && pin && !last_q) begin
            rises <= rises + 16'h1;
        end
        last_q <= pin;
    end
endmodule

`default_nettype wire

// ---- verification/ocm_channel_tb.sv ----
// Purpose : Self-checking bench for the output compare channel
// Assumes : Pin edge counts start at the control write
// Notes   : Short periods keep each mode brief
`include "ocm_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module ocm_channel_tb;
    localparam logic [2:0]  MT [4] = '{3'h3, 3'h5, 3'h6, 3'h7};
    localparam logic [15:0] PP [4] = '{16'h3, 16'h2, 16'h4, 16'h2};
    localparam logic [15:0] SS [4] = '{16'h7, 16'h5, 16'h7, 16'h7};
    localparam logic [31:0] WH [4] = '{32'ha, 32'h3, 32'h4, 32'h5};
    localparam logic [31:0] WL [4] = '{32'ha, 32'h7, 32'h6, 32'h5};

    logic ref_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic pin, oe, pulse, irq, sync;
    logic [2:0] idx;
    logic [15:0] rises;
    int mismatches = 0;
    int checked = 0;

    ocm_channel #(.CHANNEL(3'h1)) uut (
        .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .timer_sync_pin(sync),
        .compare_output_pin(pin), .compare_output_oe(oe), .trigger_generator_pulse(pulse),
        .trigger_generator_index(idx), .irq(irq)
    );
    ocm_load_model u_load (.ref_clk(ref_clk), .pin(pin), .oe(oe), .sync_pin(sync), .rises(rises));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Access and check tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= {16'h0, d};
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Bounded wait for a pin level
    task automatic wait_pin(input logic lvl, output int n);
        n = 0;
        do begin
            @(posedge ref_clk);
            #1 n++;
            if (n > 300) begin
                mismatches++;
                complete_run();
            end
        end while (pin !== lvl);
    endtask

    task automatic hold_chk(input logic lvl, input int cycles);
        repeat (cycles) begin
            @(posedge ref_clk);
            #1 chk({31'h0, pin}, {31'h0, lvl});
        end
    endtask

    task automatic irq_chk(input logic [7:0] a, input logic [15:0] d, input logic v);
        wr(a, d);
        repeat (2) @(posedge ref_clk);
        #1 chk({31'h0, irq}, {31'h0, v});
    endtask

    // Mode 000 first so values load unbuffered
    task automatic cfg(input logic [2:0] m, input logic tm, input logic [15:0] p, input logic [15:0] s,
                       input logic [15:0] t);
        wr(`OCM_OFF_CONTROL_1, 16'h0000);
        wr(`OCM_OFF_PRIMARY, p);
        wr(`OCM_OFF_SECONDARY, s);
        wr(`OCM_OFF_PERIOD, t);
        wr(`OCM_OFF_CONTROL_1, {1'b1, 11'h0, tm, m});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin : main
        logic [31:0] d;
        logic [15:0] r0;
        logic lv;
        int n;
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        rd(`OCM_OFF_CONTROL_1, d);
        chk(d, {16'h0, `OCM_RST_CONTROL});
        rd(`OCM_OFF_PERIOD, d);
        chk(d, {16'h0, `OCM_RST_PERIOD});
        rd(`OCM_OFF_IRQ_MASK, d);
        chk(d, {29'h0, `OCM_RST_MASK});
        rd(8'h20, d);
        chk(d, 32'h0);
        chk({29'h0, idx}, 32'h4);
        cfg(`OCM_MODE_SS_HIGH, 1'b0, 16'h3, 16'h7, 16'h14);
        wait_pin(1'b1, n);
        chk(n, 32'h5);
        hold_chk(1'b1, 30);
        cfg(`OCM_MODE_SS_LOW, 1'b0, 16'h3, 16'h7, 16'h14);
        wait_pin(1'b1, n);
        chk(n, 32'h1);
        wait_pin(1'b0, n);
        chk(n, 32'h4);
        hold_chk(1'b0, 30);
        r0 = rises;
        cfg(`OCM_MODE_DBL_SHOT, 1'b0, 16'h2, 16'h5, 16'h9);
        wait_pin(1'b1, n);
        chk(n, 32'h4);
        wait_pin(1'b0, n);
        chk(n, 32'h3);
        hold_chk(1'b0, 30);
        chk({16'h0, rises - r0}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            cfg(MT[i], 1'b0, PP[i], SS[i], 16'h9);
            wait_pin(1'b1, n);
            wait_pin(1'b0, n);
            chk(n, WH[i]);
            wait_pin(1'b1, n);
            chk(n, WL[i]);
        end
        // Mid-period primary write waits for next period
        cfg(`OCM_MODE_PWM_EDGE, 1'b0, 16'h4, 16'h7, 16'h9);
        wait_pin(1'b1, n);
        wr(`OCM_OFF_PRIMARY, 16'h6);
        wait_pin(1'b0, n);
        chk(n, 32'h2);
        wait_pin(1'b1, n);
        wait_pin(1'b0, n);
        chk(n, 32'h6);
        @(posedge ref_clk);
        clk_en <= 1'b0;
        #1 lv = pin;
        hold_chk(lv, 25);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        for (int t = 0; t < 2; t++) begin
            cfg(`OCM_MODE_TOGGLE, t[0], 16'h2, 16'h6, 16'h9);
            wait_pin(1'b1, n);
            rd(`OCM_OFF_CONTROL_2, d);
            chk({31'h0, d[`OCM_POS_TRIG_FLAG]}, 32'h1);
            repeat (2) @(posedge ref_clk);
            rd(`OCM_OFF_CONTROL_2, d);
            chk({31'h0, d[`OCM_POS_TRIG_FLAG]}, {31'h0, ~t[0]});
            wr(`OCM_OFF_CONTROL_1, {12'h0, t[0], `OCM_MODE_TOGGLE});
            wr(`OCM_OFF_CONTROL_2, 16'h0);
            rd(`OCM_OFF_CONTROL_2, d);
            chk({31'h0, d[`OCM_POS_TRIG_FLAG]}, 32'h0);
        end
        rd(`OCM_OFF_IRQ_STATUS, d);
        chk(d, 32'h7);
        chk({31'h0, irq}, 32'h0);
        irq_chk(`OCM_OFF_IRQ_MASK, 16'h1, 1'b1);
        irq_chk(`OCM_OFF_IRQ_STATUS, 16'h1, 1'b0);
        rd(`OCM_OFF_IRQ_STATUS, d);
        chk(d, 32'h6);
        irq_chk(`OCM_OFF_IRQ_MASK, 16'h6, 1'b1);
        irq_chk(`OCM_OFF_IRQ_STATUS, 16'h6, 1'b0);
        cfg(`OCM_MODE_OFF, 1'b0, 16'h2, 16'h5, 16'h9);
        hold_chk(1'b0, 20);
        chk({31'h0, oe}, 32'h0);
        complete_run();
    end
endmodule

`default_nettype wire
